// [core/mde_top.sv]
/*
  MAC DMA error reporting: error status and pulse interrupts for the
  transmit/receive MAC DMA and buffer RAM DMA, function call results,
  store-and-forward frame start, and a Wishbone register file.
  Assumes all inputs are synchronous to MCLK_I and event inputs are
  one-cycle pulses from the DMA engines and the MAC.
*/
`timescale 1ns/1ns

module mde_top (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire mde_pkg::mde_tx_evt_t TX_EVT_I,
  input wire logic RX_DMA_ERR_I,
  input wire logic BRAM_UNALLOC_I,
  input wire mde_pkg::mde_call_req_t CALL_I,
  output logic CALL_RET_VALID_O,
  output logic [31:0] CALL_RET_VAL_O,
  output mde_pkg::mde_xfer_cmd_t XFER_CMD_O,
  input wire logic TX_FRAME_END_I,
  input wire logic [15:0] TX_FRAME_LEN_I,
  output logic TX_START_O,
  output logic STORE_AND_FORWARD_BIT_O,
  output logic MAC_TX_DMA_ERROR_IRQ_O,
  output logic MAC_RX_DMA_ERROR_IRQ_O,
  output logic BUFFER_RAM_ACCESS_ERROR_IRQ_O,
  output logic BUF_DMA_ERROR_IRQ_O,
  output logic IRQ_O
);

  mde_pkg::mde_state_t s_r;
  mde_pkg::mde_state_t s_nxt;
  logic wb_req;
  logic tx_viol;
  logic tx_tmo;
  logic tx_any;
  logic call_ok;
  logic errstat_call;
  logic bufdma_bad;
  logic frame_ok;

  // Expands byte selects to a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Transmit error cause decode
  assign tx_viol = TX_EVT_I.unalloc | TX_EVT_I.bad_count |
                   (TX_EVT_I.desc_valid &&
                    TX_EVT_I.desc_addr != mde_pkg::DESC_END &&
                    (TX_EVT_I.desc_addr & mde_pkg::DESC_ALIGN_MASK) != '0);
  assign tx_tmo = (TX_EVT_I.desc_valid &&
                   TX_EVT_I.desc_addr == mde_pkg::DESC_END) |
                  TX_EVT_I.release_fail;
  assign tx_any = tx_viol | tx_tmo;

  // Call classification
  assign wb_req = WB_CYC_I & WB_STB_I;
  assign call_ok = CALL_I.req & CALL_I.args_ok;
  assign errstat_call = call_ok && CALL_I.id == mde_pkg::CALL_TX_ERRSTAT;
  assign bufdma_bad = call_ok && CALL_I.prohibited &&
                      (CALL_I.id == mde_pkg::CALL_BUF_DMA ||
                       CALL_I.id == mde_pkg::CALL_BUF_DMA_DESC);
  assign frame_ok = TX_FRAME_LEN_I <= mde_pkg::MAX_FRAME_LEN;

  // Next state
  always_comb begin
    logic [31:0] m;
    logic [mde_pkg::EVT_W-1:0] evt_set;
    logic [mde_pkg::EVT_W-1:0] evt_clr;
    logic [1:0] tx_clr;
    m = sel_mask(WB_SEL_I);
    evt_set = '0;
    evt_clr = '0;
    tx_clr = '0;
    s_nxt = s_r;
    s_nxt.ack = wb_req & ~s_r.ack;
    s_nxt.ret_valid = 1'b0;
    s_nxt.cmd.go = 1'b0;
    s_nxt.tx_start = 1'b0;
    // Pulse interrupts, one cycle per event
    s_nxt.tx_irq = tx_any;
    s_nxt.rx_irq = RX_DMA_ERR_I;
    s_nxt.bram_irq = BRAM_UNALLOC_I;
    s_nxt.bufdma_irq = bufdma_bad;
    evt_set[mde_pkg::EVT_TX_ERR] = tx_any;
    evt_set[mde_pkg::EVT_RX_ERR] = RX_DMA_ERR_I;
    evt_set[mde_pkg::EVT_BRAM] = BRAM_UNALLOC_I;
    evt_set[mde_pkg::EVT_BUFDMA] = bufdma_bad;
    // Frame start only after its end is in the FIFO, never for jumbos
    if (TX_FRAME_END_I) begin
      s_nxt.tx_start = frame_ok;
      evt_set[mde_pkg::EVT_JUMBO] = ~frame_ok;
    end
    // Function calls answer one cycle later
    if (CALL_I.req) begin
      s_nxt.ret_valid = 1'b1;
      s_nxt.ret_val = mde_pkg::RET_OK;
      if (!CALL_I.args_ok) begin
        s_nxt.ret_val = mde_pkg::RET_INVALID;
      end else begin
        unique case (CALL_I.id)
          mde_pkg::CALL_TX_ERRSTAT: begin
            s_nxt.ret_val = {30'h0000_0000, s_r.tx_err};
            tx_clr = 2'h3;
          end
          mde_pkg::CALL_DIRECT_COPY, mde_pkg::CALL_DIRECT_REPLACE: begin
            if (CALL_I.prohibited) begin
              s_nxt.ret_val = mde_pkg::RET_EXCEPT;
            end else begin
              s_nxt.cmd.go = 1'b1;
              s_nxt.cmd.kind = CALL_I.id;
              s_nxt.cmd.src = CALL_I.arg0;
              s_nxt.cmd.dst = CALL_I.arg1;
            end
          end
          mde_pkg::CALL_BUF_DMA, mde_pkg::CALL_BUF_DMA_DESC: begin
            if (!CALL_I.prohibited) begin
              s_nxt.cmd.go = 1'b1;
              s_nxt.cmd.kind = CALL_I.id;
              s_nxt.cmd.src = CALL_I.arg0;
              s_nxt.cmd.dst = CALL_I.arg1;
            end
          end
          default: begin
            s_nxt.ret_val = mde_pkg::RET_INVALID;
          end
        endcase
      end
    end
    // Register writes
    if (wb_req && !s_r.ack && WB_WE_I) begin
      unique case (WB_ADR_I)
        mde_pkg::OFS_TX_MODE: begin
          if (m[mde_pkg::FWD_BIT_POS]) begin
            s_nxt.store_fwd = WB_DAT_I[mde_pkg::FWD_BIT_POS];
          end
        end
        mde_pkg::OFS_EVT_STS: begin
          evt_clr = WB_DAT_I[mde_pkg::EVT_W-1:0] & m[mde_pkg::EVT_W-1:0];
        end
        mde_pkg::OFS_EVT_MASK: begin
          s_nxt.evt_mask = (s_r.evt_mask & ~m[mde_pkg::EVT_W-1:0]) |
                           (WB_DAT_I[mde_pkg::EVT_W-1:0] &
                            m[mde_pkg::EVT_W-1:0]);
        end
        default: begin
        end
      endcase
    end
    // Sticky bits, a new event beats a clear in the same cycle
    s_nxt.evt_sts = (s_r.evt_sts & ~evt_clr) | evt_set;
    s_nxt.tx_err = (s_r.tx_err & ~tx_clr) |
                   {tx_tmo, tx_viol};
    // Register reads, unmapped addresses read as zero
    s_nxt.rdata = '0;
    if (wb_req && !s_r.ack && !WB_WE_I) begin
      unique case (WB_ADR_I)
        mde_pkg::OFS_TX_MODE:
          s_nxt.rdata[mde_pkg::FWD_BIT_POS] = s_r.store_fwd;
        mde_pkg::OFS_EVT_STS: s_nxt.rdata[mde_pkg::EVT_W-1:0] = s_r.evt_sts;
        mde_pkg::OFS_EVT_MASK: s_nxt.rdata[mde_pkg::EVT_W-1:0] = s_r.evt_mask;
        mde_pkg::OFS_TX_ERR: s_nxt.rdata[1:0] = s_r.tx_err;
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_r <= mde_pkg::ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign WB_DAT_O = s_r.rdata;
  assign WB_ACK_O = s_r.ack;
  assign CALL_RET_VALID_O = s_r.ret_valid;
  assign CALL_RET_VAL_O = s_r.ret_val;
  assign XFER_CMD_O = s_r.cmd;
  assign TX_START_O = s_r.tx_start;
  assign STORE_AND_FORWARD_BIT_O = s_r.store_fwd;
  assign MAC_TX_DMA_ERROR_IRQ_O = s_r.tx_irq;
  assign MAC_RX_DMA_ERROR_IRQ_O = s_r.rx_irq;
  assign BUFFER_RAM_ACCESS_ERROR_IRQ_O = s_r.bram_irq;
  assign BUF_DMA_ERROR_IRQ_O = s_r.bufdma_irq;
  assign IRQ_O = |(s_r.evt_sts & s_r.evt_mask);

  // Invalid argument gives the invalid code next cycle
  property p_invalid_ret;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    CALL_I.req && !CALL_I.args_ok |=>
      CALL_RET_VALID_O && CALL_RET_VAL_O == mde_pkg::RET_INVALID;
  endproperty
  a_invalid_ret: assert property (p_invalid_ret)
    else $error("invalid argument not reported");

  // Receive DMA error pulses its interrupt and sets status
  property p_rx_irq;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    RX_DMA_ERR_I |=> MAC_RX_DMA_ERROR_IRQ_O &&
                     s_r.evt_sts[mde_pkg::EVT_RX_ERR];
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive DMA error interrupt missing");

  // Misaligned descriptor flags violation
  property p_viol;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    TX_EVT_I.desc_valid && TX_EVT_I.desc_addr[2:0] != 3'h0 &&
    TX_EVT_I.desc_addr != mde_pkg::DESC_END |=>
      s_r.tx_err[mde_pkg::TX_ERR_VIOL];
  endproperty
  a_viol: assert property (p_viol)
    else $error("violation bit not set");

  // End marker flags timeout and pulses the interrupt
  property p_tmo;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    TX_EVT_I.desc_valid && TX_EVT_I.desc_addr == mde_pkg::DESC_END |=>
      s_r.tx_err[mde_pkg::TX_ERR_TMO] && MAC_TX_DMA_ERROR_IRQ_O;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout bit not set");

  // Prohibited copy returns an exception and starts nothing
  property p_except;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    call_ok && CALL_I.prohibited &&
    (CALL_I.id == mde_pkg::CALL_DIRECT_COPY ||
     CALL_I.id == mde_pkg::CALL_DIRECT_REPLACE) |=>
      CALL_RET_VAL_O == mde_pkg::RET_EXCEPT && !XFER_CMD_O.go &&
      !BUF_DMA_ERROR_IRQ_O;
  endproperty
  a_except: assert property (p_except)
    else $error("copy exception not returned");

  // Prohibited buffer DMA start interrupts instead of an exception
  property p_bufdma_irq;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    bufdma_bad |=> BUF_DMA_ERROR_IRQ_O &&
                   CALL_RET_VAL_O == mde_pkg::RET_OK ##1 !BUF_DMA_ERROR_IRQ_O
                   || $past(bufdma_bad);
  endproperty
  a_bufdma_irq: assert property (p_bufdma_irq)
    else $error("buffer DMA error interrupt missing");

  // Copy arguments map first to source, second to destination
  property p_copy_args;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    call_ok && !CALL_I.prohibited &&
    CALL_I.id == mde_pkg::CALL_DIRECT_COPY |=>
      XFER_CMD_O.go && XFER_CMD_O.src == $past(CALL_I.arg0) &&
      XFER_CMD_O.dst == $past(CALL_I.arg1);
  endproperty
  a_copy_args: assert property (p_copy_args)
    else $error("copy arguments swapped");

  // Any transmit error pulses the interrupt exactly then
  property p_tx_irq;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ##1 MAC_TX_DMA_ERROR_IRQ_O == $past(tx_any);
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit error interrupt wrong");

  // Buffer RAM error interrupt follows the event for one cycle
  property p_bram;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    BRAM_UNALLOC_I ##1 !BRAM_UNALLOC_I |=>
      !BUFFER_RAM_ACCESS_ERROR_IRQ_O && $past(BUFFER_RAM_ACCESS_ERROR_IRQ_O);
  endproperty
  a_bram: assert property (p_bram)
    else $error("buffer RAM interrupt not a pulse");

  // Start comes only right after an in-limit frame end
  property p_start;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ##1 TX_START_O == $past(TX_FRAME_END_I && frame_ok);
  endproperty
  a_start: assert property (p_start)
    else $error("frame start wrong");

  // Error bits only clear through the status call
  property p_hold;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    !errstat_call |=> (s_r.tx_err & $past(s_r.tx_err)) == $past(s_r.tx_err);
  endproperty
  a_hold: assert property (p_hold)
    else $error("transmit error bits lost");

endmodule

// [common/mde_pkg.sv]
/*
  Shared constants and types for the MAC DMA error reporting block:
  register offsets, field positions, reset values, call codes and carriers.
  Assumes a 32-bit classic Wishbone slave port and byte addresses.
*/
package mde_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_TX_MODE = 8'h00;
  localparam logic [7:0] OFS_EVT_STS = 8'h04;
  localparam logic [7:0] OFS_EVT_MASK = 8'h08;
  localparam logic [7:0] OFS_TX_ERR = 8'h0C;

  // Field positions
  localparam int FWD_BIT_POS = 29;
  localparam int EVT_W = 5;
  localparam int EVT_TX_ERR = 0;
  localparam int EVT_RX_ERR = 1;
  localparam int EVT_BRAM = 2;
  localparam int EVT_BUFDMA = 3;
  localparam int EVT_JUMBO = 4;
  localparam int TX_ERR_VIOL = 0;
  localparam int TX_ERR_TMO = 1;

  // Descriptor checks and frame limit
  localparam logic [31:0] DESC_END = 32'hFFFF_FFFF;
  localparam logic [31:0] DESC_ALIGN_MASK = 32'h0000_0007;
  localparam logic [15:0] MAX_FRAME_LEN = 16'h05EE;

  // Return value codes (values are arbitrary)
  localparam logic [31:0] RET_OK = 32'h0000_0000;
  localparam logic [31:0] RET_INVALID = 32'hFFFF_FFEF;
  localparam logic [31:0] RET_EXCEPT = 32'hFFFF_FFF0;

  // Hardware function call codes
  typedef enum logic [2:0] {
    CALL_TX_ERRSTAT = 3'h0,
    CALL_DIRECT_COPY = 3'h1,
    CALL_DIRECT_REPLACE = 3'h2,
    CALL_BUF_DMA = 3'h3,
    CALL_BUF_DMA_DESC = 3'h4
  } mde_call_t;

  // Transmit MAC DMA error sources
  typedef struct packed {
    logic unalloc;
    logic bad_count;
    logic desc_valid;
    logic [31:0] desc_addr;
    logic release_fail;
  } mde_tx_evt_t;

  // Function call request from the CPU side
  typedef struct packed {
    logic req;
    mde_call_t id;
    logic args_ok;
    logic prohibited;
    logic [31:0] arg0;
    logic [31:0] arg1;
  } mde_call_req_t;

  // Transfer command to the buffer RAM DMA engine
  typedef struct packed {
    logic go;
    mde_call_t kind;
    logic [31:0] src;
    logic [31:0] dst;
  } mde_xfer_cmd_t;

  // Whole state of the block
  typedef struct packed {
    logic store_fwd;
    logic [EVT_W-1:0] evt_sts;
    logic [EVT_W-1:0] evt_mask;
    logic [1:0] tx_err;
    logic ack;
    logic [31:0] rdata;
    logic ret_valid;
    logic [31:0] ret_val;
    logic tx_irq;
    logic rx_irq;
    logic bram_irq;
    logic bufdma_irq;
    logic tx_start;
    mde_xfer_cmd_t cmd;
  } mde_state_t;

  localparam mde_state_t ST_RST = '{store_fwd: 1'b1, default: '0};

endpackage

// [tb/mde_far_model.sv]
/*
  Far-side model: the CPU issuing hardware function calls and the MAC
  and DMA engines reporting events, each as a one-cycle request.
  Assumes the caller waits for each task to return before the next one.
*/
`timescale 1ns/1ns

module mde_far_model (
  input wire logic clk_i,
  output mde_pkg::mde_call_req_t call_o,
  output mde_pkg::mde_tx_evt_t tx_evt_o,
  output logic rx_err_o,
  output logic bram_unalloc_o,
  output logic frame_end_o,
  output logic [15:0] frame_len_o
);
  // Quiet lines at time zero
  initial begin
    call_o = '0;
    tx_evt_o = '0;
    rx_err_o = 1'b0;
    bram_unalloc_o = 1'b0;
    frame_end_o = 1'b0;
    frame_len_o = 16'h0000;
  end

  // One call; released fields turn to garbage so stale values are not used
  task automatic call(input logic [2:0] id, input logic ok, input logic proh,
                      input logic [31:0] src, input logic [31:0] dst);
    @(posedge clk_i);
    call_o <= '{req: 1'b1, id: mde_pkg::mde_call_t'(id), args_ok: ok,
                prohibited: proh, arg0: src, arg1: dst};
    @(posedge clk_i);
    call_o <= '{req: 1'b0, id: mde_pkg::mde_call_t'(~id), args_ok: ~ok,
                prohibited: ~proh, arg0: ~src, arg1: ~dst};
  endtask

  // One transmit DMA event cycle
  task automatic tx(input mde_pkg::mde_tx_evt_t e);
    @(posedge clk_i);
    tx_evt_o <= e;
    @(posedge clk_i);
    tx_evt_o <= '{desc_addr: ~e.desc_addr, default: '0};
  endtask

  // Receive error (0), unacquired buffer access (1) or frame end (2)
  task automatic pulse(input int which, input logic [15:0] len);
    @(posedge clk_i);
    rx_err_o <= (which == 0);
    bram_unalloc_o <= (which == 1);
    frame_end_o <= (which == 2);
    frame_len_o <= len;
    @(posedge clk_i);
    rx_err_o <= 1'b0;
    bram_unalloc_o <= 1'b0;
    frame_end_o <= 1'b0;
    frame_len_o <= ~len;
  endtask
endmodule

// [tb/tb.sv]
/*
  Self-checking bench for the error reporting block: register file over
  classic Wishbone, calls, transmit errors, pulses and the interrupt line.
  Assumes the far-side model and the package are compiled first.
*/
`timescale 1ns/1ns

`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
      n_fail++; \
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module tb;
  logic MCLK_I, RST_N_I, WB_CYC_I, WB_STB_I, WB_WE_I;
  logic [7:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, CALL_RET_VAL_O, seed, r, rd;
  logic WB_ACK_O, CALL_RET_VALID_O, TX_START_O, STORE_AND_FORWARD_BIT_O;
  logic MAC_TX_DMA_ERROR_IRQ_O, MAC_RX_DMA_ERROR_IRQ_O, IRQ_O;
  logic BUFFER_RAM_ACCESS_ERROR_IRQ_O, BUF_DMA_ERROR_IRQ_O;
  logic rx_w, bram_w, fend_w, tmo, viol;
  logic [15:0] flen_w;
  logic [4:0] exp_sts;
  logic [1:0] exp_err;
  mde_pkg::mde_tx_evt_t tx_w, ev;
  mde_pkg::mde_call_req_t call_w;
  mde_pkg::mde_xfer_cmd_t XFER_CMD_O;
  int n_fail, n_compared;

  mde_top u_dut (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .TX_EVT_I(tx_w), .RX_DMA_ERR_I(rx_w),
    .BRAM_UNALLOC_I(bram_w), .CALL_I(call_w),
    .CALL_RET_VALID_O(CALL_RET_VALID_O), .CALL_RET_VAL_O(CALL_RET_VAL_O),
    .XFER_CMD_O(XFER_CMD_O), .TX_FRAME_END_I(fend_w),
    .TX_FRAME_LEN_I(flen_w), .TX_START_O(TX_START_O),
    .STORE_AND_FORWARD_BIT_O(STORE_AND_FORWARD_BIT_O),
    .MAC_TX_DMA_ERROR_IRQ_O(MAC_TX_DMA_ERROR_IRQ_O),
    .MAC_RX_DMA_ERROR_IRQ_O(MAC_RX_DMA_ERROR_IRQ_O),
    .BUFFER_RAM_ACCESS_ERROR_IRQ_O(BUFFER_RAM_ACCESS_ERROR_IRQ_O),
    .BUF_DMA_ERROR_IRQ_O(BUF_DMA_ERROR_IRQ_O), .IRQ_O(IRQ_O));

  mde_far_model u_far (.clk_i(MCLK_I), .call_o(call_w), .tx_evt_o(tx_w),
    .rx_err_o(rx_w), .bram_unalloc_o(bram_w), .frame_end_o(fend_w),
    .frame_len_o(flen_w));

  // Fixed-seed xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Verdict and end of run
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Classic Wishbone single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] wd, output logic [31:0] rdv);
    int k;
    @(posedge MCLK_I);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= wd;
    k = 0;
    do begin
      @(posedge MCLK_I);
      k++;
    end while (WB_ACK_O !== 1'b1);
    `CHK("wb ack", 1'b1, WB_ACK_O)
    `CHK("wb wait", 2, k)
    rdv = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask

  // One call checked against the reference outcome
  task automatic do_call(input logic [2:0] id, input logic ok,
                         input logic proh, input logic [31:0] a0,
                         input logic [31:0] a1);
    logic [31:0] ret;
    logic go, berr;
    ret = mde_pkg::RET_OK;
    go = 1'b0;
    berr = 1'b0;
    if (!ok || id > 3'h4) ret = mde_pkg::RET_INVALID;
    else if (id == 3'h0) begin
      ret = {30'h0, exp_err};
      exp_err = 2'b00;
    end
    else if (proh && id < 3'h3) ret = mde_pkg::RET_EXCEPT;
    else if (proh) berr = 1'b1;
    else go = 1'b1;
    if (berr) exp_sts[3] = 1'b1;
    u_far.call(id, ok, proh, a0, a1);
    #1;
    `CHK("ret valid", 1'b1, CALL_RET_VALID_O)
    `CHK("ret value", ret, CALL_RET_VAL_O)
    `CHK("xfer go", go, XFER_CMD_O.go)
    `CHK("buf dma irq", berr, BUF_DMA_ERROR_IRQ_O)
    if (go) begin
      `CHK("xfer kind", id, XFER_CMD_O.kind)
      `CHK("xfer src", a0, XFER_CMD_O.src)
      `CHK("xfer dst", a1, XFER_CMD_O.dst)
    end
  endtask

  // Receive error, unacquired access or frame end, then the drop of the buffer RAM interrupt and the start
  task automatic do_evt(input int which, input logic [15:0] len);
    logic st;
    st = (which == 2) && (len <= 16'h05EE);
    if (which < 2) exp_sts[which + 1] = 1'b1;
    if (which == 2 && !st) exp_sts[4] = 1'b1;
    u_far.pulse(which, len);
    #1;
    `CHK("rx irq", which == 0, MAC_RX_DMA_ERROR_IRQ_O)
    `CHK("bram irq", which == 1, BUFFER_RAM_ACCESS_ERROR_IRQ_O)
    `CHK("tx start", st, TX_START_O)
    @(posedge MCLK_I);
    #1;
    `CHK("bram irq drop", 1'b0, BUFFER_RAM_ACCESS_ERROR_IRQ_O)
    `CHK("tx start drop", 1'b0, TX_START_O)
  endtask

  // Clock
  initial begin
    MCLK_I = 1'b0;
    forever #25 MCLK_I = ~MCLK_I;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge MCLK_I);
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    seed = 32'h0000_1D20;
    exp_sts = 5'h00;
    exp_err = 2'b00;
    RST_N_I = 1'b0;
    {WB_CYC_I, WB_STB_I, WB_WE_I} = 3'h0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'hF;
    WB_DAT_I = 32'h0000_0000;
    repeat (3) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    #1;
    `CHK("store fwd pin", 1'b1, STORE_AND_FORWARD_BIT_O)
    wb(1'b1, mde_pkg::OFS_TX_MODE, 32'hFFFF_FFFF, rd);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0, rd);
      `CHK("reg reset", (i == 0) ? 32'h2000_0000 : 32'h0, rd)
    end
    for (int i = 1; i < 5; i++) begin
      do_call(3'(i), 1'b1, 1'b1, xs(), xs());
      do_call(3'(i), 1'b1, 1'b0, xs(), xs());
    end
    for (int i = 0; i < 24; i++) begin
      r = xs();
      do_call(3'h1 + 3'(r % 7), r[8] | r[9], r[10], xs(), xs());
    end
    for (int i = 0; i < 6; i++) begin
      ev = '0;
      case (i)
        0: ev.unalloc = 1'b1;
        1: ev.bad_count = 1'b1;
        4: ev.release_fail = 1'b1;
        default: begin
          ev.desc_valid = 1'b1;
          ev.desc_addr = (i == 2) ? 32'h0000_1004 :
                         (i == 3) ? 32'hFFFF_FFFF : 32'h0000_1008;
        end
      endcase
      tmo = (ev.desc_valid && ev.desc_addr == 32'hFFFF_FFFF) ||
            ev.release_fail;
      viol = ev.unalloc || ev.bad_count ||
             (ev.desc_valid && ev.desc_addr != 32'hFFFF_FFFF &&
              ev.desc_addr[2:0] != 3'h0);
      exp_err = {tmo, viol};
      if (tmo || viol) exp_sts[0] = 1'b1;
      u_far.tx(ev);
      #1;
      `CHK("tx irq", tmo | viol, MAC_TX_DMA_ERROR_IRQ_O)
      repeat (3) @(posedge MCLK_I);
      #1;
      `CHK("tx irq drop", 1'b0, MAC_TX_DMA_ERROR_IRQ_O)
      wb(1'b0, mde_pkg::OFS_TX_ERR, 32'h0, rd);
      `CHK("tx err reg", {30'h0, exp_err}, rd)
      do_call(3'h0, 1'b1, 1'b0, xs(), xs());
    end
    do_evt(0, 16'h0000);
    do_evt(1, 16'h0000);
    do_evt(2, 16'h05EE);
    do_evt(2, 16'h05EF);
    wb(1'b1, mde_pkg::OFS_EVT_MASK, xs(), rd);
    wb(1'b1, mde_pkg::OFS_EVT_MASK, 32'h0000_0004, rd);
    wb(1'b0, mde_pkg::OFS_EVT_MASK, 32'h0, rd);
    `CHK("mask", 32'h0000_0004, rd)
    @(posedge MCLK_I);
    #1;
    `CHK("irq on", 1'b1, IRQ_O)
    wb(1'b0, mde_pkg::OFS_EVT_STS, 32'h0, rd);
    `CHK("status", {27'h0, exp_sts}, rd)
    wb(1'b1, mde_pkg::OFS_EVT_STS, 32'h0000_0004, rd);
    exp_sts[2] = 1'b0;
    @(posedge MCLK_I);
    #1;
    `CHK("irq off", 1'b0, IRQ_O)
    wb(1'b0, mde_pkg::OFS_EVT_STS, 32'h0, rd);
    `CHK("status w1c", {27'h0, exp_sts}, rd)
    // Reset in mid-run brings every register back to its reset value
    RST_N_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    exp_sts = 5'h00;
    #1;
    `CHK("irq reset", 1'b0, IRQ_O)
    `CHK("store fwd reset", 1'b1, STORE_AND_FORWARD_BIT_O)
    wb(1'b0, mde_pkg::OFS_EVT_STS, 32'h0, rd);
    `CHK("status reset", {27'h0, exp_sts}, rd)
    wb(1'b0, mde_pkg::OFS_TX_MODE, 32'h0, rd);
    `CHK("mode reset", 32'h2000_0000, rd)
    stop_test();
  end
endmodule
